// ==== bench/tb.sv ====
// self-checking bench joining resolver and core ends
`timescale 1ns/1ps
module tb;
  import vpr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq_enable = 1'b0;
  logic sw_level_we = 1'b0, sw_return = 1'b0, take_ff, exception_level_bit_ff;
  logic current_set_number_ff, previous_set_number_ff, mv, ss, seen;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, r, handler_addr_ff;
  logic [31:0] exception_base = 32'hBD00_0000;
  logic [63:0] src_event = 64'h0, pend, ena;
  logic [4:0]  vector_spacing = 5'h02;
  logic [2:0]  sw_level = 3'h0, current_core_level_ff, shl;
  int error_cnt = 0, compares = 0, cyc = 0, seed = 22;
  int pri[64], sub[64], it, k, j, lv, vec;
  vpr_link_if link ();

  vpr_resolver i_vpr_resolver (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .src_event,
    .link(link.dev));
  vpr_core_end i_vpr_core_end (.pclk, .presetn, .link(link.core),
    .irq_enable, .sw_level_we, .sw_level, .sw_return, .exception_base,
    .vector_spacing, .take_ff, .handler_addr_ff, .current_set_number_ff,
    .previous_set_number_ff, .current_core_level_ff,
    .exception_level_bit_ff);
  vpr_monitor i_vpr_monitor (.pclk, .presetn,
    .requested_level(link.requested_level),
    .vector_number(link.vector_number), .set_select(link.set_select),
    .current_core_level(link.current_core_level), .take_ff,
    .current_set_number_ff, .previous_set_number_ff,
    .exception_level_bit_ff);

  //////////////////////////////////////////////////////////////////////////
  always #10 pclk = ~pclk;
  // ceiling well above the roughly 3000 cycles the sequence needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // idle cycle after each transfer keeps psel from two writes in one step
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic err);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic ev(int v);
    src_event <= 64'h1 << v;
    @(posedge pclk);
    src_event <= 64'h0;
  endtask

  function automatic logic [31:0] adr(int v);
    return exception_base + VPR_VEC_OFS +
           32'(v) * ({27'h0, vector_spacing} << 5);
  endfunction

  // behavioural ranking: strict compare keeps the lower vector on ties
  function automatic void best();
    int bs;
    lv = 0;
    vec = 0;
    bs = -1;
    for (int v = 0; v < 64; v++)
      if (pend[v] && ena[v] && pri[v] != 0 &&
          (pri[v] > lv || (pri[v] == lv && sub[v] > bs))) begin
        lv = pri[v];
        bs = sub[v];
        vec = v;
      end
  endfunction

  task automatic wait_take(logic [31:0] a, logic set);
    int n;
    n = 0;
    while (take_ff !== 1'b1 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    chk("take", 32'h1, {31'h0, take_ff});
    chk("handler_addr", a, handler_addr_ff);
    chk("cur_set", {31'h0, set}, {31'h0, current_set_number_ff});
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, VPR_CTRL_OFS, 32'h0, 1'b0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, VPR_STAT_OFS, 32'h0, 1'b0);
    chk("stat", 32'h0, rd);
    apb(1'b0, 12'h008, 32'h0, 1'b1);
    chk("unmapped", 32'h0, rd);
    for (it = 0; it < 24; it++) begin
      r = $random(seed) & 32'h0001_1700;
      mv = r[12];
      ss = r[16];
      shl = r[10:8];
      apb(1'b1, VPR_CTRL_OFS, r, 1'b0);
      for (k = 0; k < 16; k++) begin
        r = $random(seed);
        for (j = 0; j < 4; j++) begin
          pri[4*k+j] = r[8*j+2 +: 3];
          sub[4*k+j] = r[8*j +: 2];
        end
        apb(1'b1, VPR_PCFG_OFS + 12'(4*k), r, 1'b0);
        apb(1'b0, VPR_PCFG_OFS + 12'(4*k), 32'h0, 1'b0);
        chk("pcfg", r & 32'h1F1F_1F1F, rd);
      end
      ena = {$random(seed), $random(seed)};
      apb(1'b1, VPR_ENA0_OFS, ena[31:0], 1'b0);
      apb(1'b1, VPR_ENA1_OFS, ena[63:32], 1'b0);
      apb(1'b1, VPR_PEND0_OFS, 32'h0, 1'b0);
      apb(1'b1, VPR_PEND1_OFS, 32'h0, 1'b0);
      pend[31:0] = $random(seed) & $random(seed) & $random(seed);
      pend[63:32] = $random(seed) & $random(seed) & $random(seed);
      src_event <= pend;
      @(posedge pclk);
      src_event <= 64'h0;
      repeat (3) @(posedge pclk);
      apb(1'b0, VPR_STAT_OFS, 32'h0, 1'b0);
      best();
      chk("req_level", 32'(lv), {29'h0, rd[2:0]});
      if (lv != 0) begin
        r = mv ? 32'(vec) : 32'h0;
        chk("vector", r, {26'h0, rd[13:8]});
        r = mv ? 32'(lv == shl) : 32'(ss);
        chk("set_sel", r, {31'h0, rd[16]});
      end
    end
    for (k = 0; k < 16; k++)
      apb(1'b1, VPR_PCFG_OFS + 12'(4*k), 32'h0, 1'b0);
    apb(1'b1, VPR_CTRL_OFS, 32'h0000_1500, 1'b0);
    apb(1'b1, VPR_PCFG_OFS + 12'h010, 32'h0000_0C0C, 1'b0);
    apb(1'b1, VPR_PCFG_OFS + 12'h028, 32'h0000_0014, 1'b0);
    apb(1'b1, VPR_ENA0_OFS, 32'hFFFF_FFFF, 1'b0);
    apb(1'b1, VPR_ENA1_OFS, 32'hFFFF_FFFF, 1'b0);
    apb(1'b1, VPR_PEND0_OFS, 32'h0, 1'b0);
    apb(1'b1, VPR_PEND1_OFS, 32'h0, 1'b0);
    irq_enable <= 1'b1;
    ev(16);
    wait_take(adr(16), 1'b0);
    sw_level <= 3'h3;
    sw_level_we <= 1'b1;
    @(posedge pclk);
    sw_level_we <= 1'b0;
    apb(1'b1, VPR_PEND0_OFS, 32'h0, 1'b0);
    chk("core_level", 32'h3, {29'h0, current_core_level_ff});
    ev(17);
    seen = 1'b0;
    repeat (12) begin
      @(posedge pclk);
      seen = seen | take_ff;
    end
    chk("equal_level_take", 32'h0, {31'h0, seen});
    ev(40);
    wait_take(adr(40), 1'b1);
    chk("prev_set", 32'h0, {31'h0, previous_set_number_ff});
    apb(1'b1, VPR_PEND1_OFS, 32'h0, 1'b0);
    sw_return <= 1'b1;
    @(posedge pclk);
    sw_return <= 1'b0;
    @(posedge pclk);
    chk("ret_level", 32'h3, {29'h0, current_core_level_ff});
    apb(1'b1, VPR_CTRL_OFS, 32'h0001_0000, 1'b0);
    ev(40);
    wait_take(adr(0), 1'b1);
    // raise level, clear the flag, then lower: only vector 17 comes back
    sw_level <= 3'h5;
    sw_level_we <= 1'b1;
    @(posedge pclk);
    sw_level_we <= 1'b0;
    apb(1'b1, VPR_PEND1_OFS, 32'h0, 1'b0);
    sw_level <= 3'h0;
    sw_level_we <= 1'b1;
    @(posedge pclk);
    sw_level_we <= 1'b0;
    wait_take(adr(0), 1'b1);
    chk("prev_set", 32'h1, {31'h0, previous_set_number_ff});
    wrap_up();
  end
endmodule

// ==== bench/vpr_monitor.sv ====
// link and core-take assertions beside the resolver to core link
`timescale 1ns/1ps
module vpr_monitor (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // link
  input wire logic [2:0] requested_level,
  input wire logic [5:0] vector_number,
  input wire logic       set_select,
  input wire logic [2:0] current_core_level,
  // core observation
  input wire logic       take_ff,
  input wire logic       current_set_number_ff,
  input wire logic       previous_set_number_ff,
  input wire logic       exception_level_bit_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  //////////////////////////////////////////////////////////////////////////
  AST_RST_IDLE: assert property (
    $rose(presetn) |-> requested_level == 3'h0 && vector_number == 6'h0
    && current_core_level == 3'h0) else $error("link busy after reset");
  AST_TAKE_ABOVE: assert property (
    take_ff |-> $past(requested_level) > $past(current_core_level))
    else $error("take not above core level");
  AST_LVL_BELOW: assert property (
    requested_level <= current_core_level |=> !take_ff)
    else $error("take at or below core level");
  AST_TAKE_SET: assert property (
    take_ff |-> current_set_number_ff == $past(set_select))
    else $error("set number not from link");
  AST_TAKE_PREV: assert property (
    take_ff |-> previous_set_number_ff == $past(current_set_number_ff))
    else $error("previous set not kept");
  AST_TAKE_EXC: assert property (
    take_ff |-> exception_level_bit_ff) else $error("take without exception");
  AST_TAKE_ONE: assert property (
    take_ff |=> !take_ff) else $error("take longer than one cycle");
  AST_EXC_NO_TAKE: assert property (
    exception_level_bit_ff |=> !take_ff) else $error("take in exception");
endmodule

// ==== design/vpr_core_end.sv ====
// processor core end: takes vectored requests, keeps level and set state
`timescale 1ns/1ps
module vpr_core_end (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // link to the resolver
  vpr_link_if.core         link,
  // handler software side
  input  wire logic        irq_enable,
  input  wire logic        sw_level_we,
  input  wire logic [2:0]  sw_level,
  input  wire logic        sw_return,
  input  wire logic [31:0] exception_base,
  input  wire logic [4:0]  vector_spacing,
  // observation
  output logic             take_ff,
  output logic [31:0]      handler_addr_ff,
  output logic             current_set_number_ff,
  output logic             previous_set_number_ff,
  output logic [2:0]       current_core_level_ff,
  output logic             exception_level_bit_ff
);
  import vpr_pkg::*;

  vpr_core_st_t st_ff, nxt_st_ff;
  logic         nxt_take_ff;
  logic [31:0]  nxt_handler_addr_ff;
  logic         nxt_current_set_number_ff;
  logic         nxt_previous_set_number_ff;
  logic [2:0]   nxt_current_core_level_ff;
  logic [2:0]   saved_level_ff, nxt_saved_level_ff;
  logic         take;
  logic [15:0]  vec_ofs;

  assign link.current_core_level = current_core_level_ff;
  // one-hot state: the exception bit is the state flop itself
  assign exception_level_bit_ff  = st_ff[1];

  // taken only while running, enabled and strictly above current level
  assign take = (st_ff == VPR_RUN) && irq_enable &&
                (link.requested_level > current_core_level_ff);

  // same formula serves single mode, where the vector is always zero
  assign vec_ofs = 16'(link.vector_number) *
                   16'({vector_spacing, 5'h00});

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st_ff                  = st_ff;
    nxt_take_ff                = take;
    nxt_handler_addr_ff        = handler_addr_ff;
    nxt_current_set_number_ff  = current_set_number_ff;
    nxt_previous_set_number_ff = previous_set_number_ff;
    nxt_current_core_level_ff  = current_core_level_ff;
    nxt_saved_level_ff         = saved_level_ff;
    case (st_ff)
      VPR_RUN: begin
        if (take) begin
          nxt_st_ff = VPR_EXC;
          nxt_handler_addr_ff = exception_base + VPR_VEC_OFS +
                                32'(vec_ofs);
          nxt_previous_set_number_ff = current_set_number_ff;
          nxt_current_set_number_ff  = link.set_select;
          nxt_saved_level_ff = current_core_level_ff;
        end else if (sw_return) begin
          // one-deep save: nested returns restore only the last level
          nxt_current_core_level_ff = saved_level_ff;
          nxt_current_set_number_ff = previous_set_number_ff;
        end else if (sw_level_we) begin
          nxt_current_core_level_ff = sw_level;
        end
      end
      VPR_EXC: begin
        // handler copies requested level and clears the exception bit
        if (sw_level_we) begin
          nxt_current_core_level_ff = sw_level;
          nxt_st_ff = VPR_RUN;
        end else if (sw_return) begin
          nxt_current_core_level_ff = saved_level_ff;
          nxt_current_set_number_ff = previous_set_number_ff;
          nxt_st_ff = VPR_RUN;
        end
      end
      default: nxt_st_ff = VPR_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff                  <= VPR_RUN;
      take_ff                <= 1'b0;
      handler_addr_ff        <= VPR_DAT_RST;
      current_set_number_ff  <= 1'b0;
      previous_set_number_ff <= 1'b0;
      current_core_level_ff  <= VPR_LVL_RST;
      saved_level_ff         <= VPR_LVL_RST;
    end else begin
      st_ff                  <= nxt_st_ff;
      take_ff                <= nxt_take_ff;
      handler_addr_ff        <= nxt_handler_addr_ff;
      current_set_number_ff  <= nxt_current_set_number_ff;
      previous_set_number_ff <= nxt_previous_set_number_ff;
      current_core_level_ff  <= nxt_current_core_level_ff;
      saved_level_ff         <= nxt_saved_level_ff;
    end
  end
endmodule

// ==== design/vpr_link_if.sv ====
// link between the priority resolver and the processor core
`timescale 1ns/1ps
interface vpr_link_if;
  logic [2:0] requested_level;
  logic [5:0] vector_number;
  logic       set_select;
  logic [2:0] current_core_level;

  modport dev (
    output requested_level,
    output vector_number,
    output set_select,
    input  current_core_level
  );

  modport core (
    input  requested_level,
    input  vector_number,
    input  set_select,
    output current_core_level
  );
endinterface

// ==== design/vpr_pkg.sv ====
// shared constants and types of the vectored priority resolver
package vpr_pkg;

  localparam int unsigned VPR_NVEC  = 64;
  localparam int unsigned VPR_LVL_W = 3;
  localparam int unsigned VPR_SUB_W = 2;
  localparam int unsigned VPR_VEC_W = 6;
  localparam int unsigned VPR_ADR_W = 12;
  localparam int unsigned VPR_DAT_W = 32;

  //////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [11:0] VPR_CTRL_OFS  = 12'h000;
  localparam logic [11:0] VPR_STAT_OFS  = 12'h004;
  localparam logic [11:0] VPR_PEND0_OFS = 12'h010;
  localparam logic [11:0] VPR_PEND1_OFS = 12'h014;
  localparam logic [11:0] VPR_ENA0_OFS  = 12'h020;
  localparam logic [11:0] VPR_ENA1_OFS  = 12'h024;
  localparam logic [11:0] VPR_PCFG_OFS  = 12'h040;
  localparam int unsigned VPR_PCFG_NREG = 16;
  localparam int unsigned VPR_VEC_PER_REG = 4;

  //////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned VPR_MULTI_VECTOR_SELECT_BIT  = 12;
  localparam int unsigned VPR_SS0_BIT   = 16;
  localparam int unsigned VPR_SHLVL_LSB = 8;
  localparam int unsigned VPR_PRI_LSB   = 2;
  localparam int unsigned VPR_SUB_LSB   = 0;
  localparam int unsigned VPR_VEC_STRIDE = 8;
  localparam int unsigned VPR_ST_LVL_LSB = 0;
  localparam int unsigned VPR_ST_VEC_LSB = 8;
  localparam int unsigned VPR_ST_SET_BIT = 16;
  localparam int unsigned VPR_ST_CUR_LSB = 24;

  //////////////////////////////////////////////////////////////////////////
  // reset values and core-side constants
  localparam logic [2:0]  VPR_LVL_RST   = 3'h0;
  localparam logic [31:0] VPR_DAT_RST   = 32'h0000_0000;
  localparam logic [31:0] VPR_VEC_OFS   = 32'h0000_0200;
  localparam int unsigned VPR_VS_SHIFT  = 5;

  typedef enum logic [1:0] {
    VPR_RUN = 2'b01,
    VPR_EXC = 2'b10
  } vpr_core_st_t;

endpackage

// ==== design/vpr_rank.sv ====
// ranking of pending vectors by level, subpriority and vector number
`timescale 1ns/1ps
module vpr_rank (
  // candidates
  input  wire logic [63:0]  req,
  input  wire logic [191:0] pri_flat,
  input  wire logic [127:0] sub_flat,
  // winner
  output logic              win_any,
  output logic [2:0]        win_lvl,
  output logic [1:0]        win_sub,
  output logic [5:0]        win_vec
);
  import vpr_pkg::*;

  always_comb begin
    win_any = 1'b0;
    win_lvl = VPR_LVL_RST;
    win_sub = 2'h0;
    win_vec = 6'h00;
    // scan downward so an equal key at a lower vector takes over
    for (int i = VPR_NVEC - 1; i >= 0; i--) begin
      if (req[i] && (!win_any ||
          {pri_flat[i*3 +: 3], sub_flat[i*2 +: 2]} >=
          {win_lvl, win_sub})) begin
        win_any = 1'b1;
        win_lvl = pri_flat[i*3 +: 3];
        win_sub = sub_flat[i*2 +: 2];
        win_vec = 6'(i);
      end
    end
  end
endmodule

// ==== design/vpr_resolver.sv ====
// resolver end: apb registers, pending flags, ranking and link request
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps

module vpr_resolver (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt events, same clock, one bit per vector
  input  wire logic [63:0] src_event,
  // link to the core
  vpr_link_if.dev          link
);
  import vpr_pkg::*;

  function automatic logic is_pcfg(input logic [11:0] a);
    return (a >= VPR_PCFG_OFS) &&
           (a < VPR_PCFG_OFS + 12'(VPR_PCFG_NREG * 4)) &&
           (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] pcfg_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - VPR_PCFG_OFS;
    return d[5:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration and flags
  logic        multi_vector_select_ff, nxt_multi_vector_select_ff;
  logic        ss0_ff, nxt_ss0_ff;
  logic [2:0]  shlvl_ff, nxt_shlvl_ff;
  logic [63:0] pend_ff, nxt_pend_ff;
  logic [63:0] ena_ff, nxt_ena_ff;
  logic [2:0]  pri_ff [64];
  logic [2:0]  nxt_pri_ff [64];
  logic [1:0]  sub_ff [64];
  logic [1:0]  nxt_sub_ff [64];
  logic        wr;

  // apb answer
  logic [31:0] prdata_ff, nxt_prdata_ff;
  logic        pready_ff, nxt_pready_ff;
  logic        pslverr_ff, nxt_pslverr_ff;
  logic [31:0] rdata;
  logic        hit;

  // link request
  logic [2:0]  lvl_ff, nxt_lvl_ff;
  logic [5:0]  vec_ff, nxt_vec_ff;
  logic        set_ff, nxt_set_ff;

  // ranking
  logic [63:0]  req;
  logic [191:0] pri_flat;
  logic [127:0] sub_flat;
  logic         win_any;
  logic [2:0]   win_lvl;
  logic [1:0]   win_sub;
  logic [5:0]   win_vec;

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign link.requested_level = lvl_ff;
  assign link.vector_number   = vec_ff;
  assign link.set_select      = set_ff;

  // write lands only at the edge that sees the ready access phase
  assign wr = psel & penable & pready_ff & pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // register read mux and decode
  always_comb begin
    rdata = VPR_DAT_RST;
    hit   = 1'b1;
    if (is_pcfg(paddr)) begin
      for (int j = 0; j < VPR_VEC_PER_REG; j++) begin
        rdata[j*VPR_VEC_STRIDE + VPR_PRI_LSB +: 3] =
          pri_ff[pcfg_idx(paddr)*4 + j];
        rdata[j*VPR_VEC_STRIDE + VPR_SUB_LSB +: 2] =
          sub_ff[pcfg_idx(paddr)*4 + j];
      end
    end else begin
      case (paddr)
        VPR_CTRL_OFS: begin
          rdata[VPR_MULTI_VECTOR_SELECT_BIT]          = multi_vector_select_ff;
          rdata[VPR_SS0_BIT]           = ss0_ff;
          rdata[VPR_SHLVL_LSB +: 3]    = shlvl_ff;
        end
        VPR_STAT_OFS: begin
          rdata[VPR_ST_LVL_LSB +: 3]   = lvl_ff;
          rdata[VPR_ST_VEC_LSB +: 6]   = vec_ff;
          rdata[VPR_ST_SET_BIT]        = set_ff;
          rdata[VPR_ST_CUR_LSB +: 3]   = link.current_core_level;
        end
        VPR_PEND0_OFS: rdata = pend_ff[31:0];
        VPR_PEND1_OFS: rdata = pend_ff[63:32];
        VPR_ENA0_OFS:  rdata = ena_ff[31:0];
        VPR_ENA1_OFS:  rdata = ena_ff[63:32];
        default:       hit   = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: zero wait, data sampled in the setup cycle
  always_comb begin
    nxt_pready_ff  = psel & ~penable;
    nxt_prdata_ff  = (psel & ~penable & ~pwrite) ? rdata : VPR_DAT_RST;
    nxt_pslverr_ff = psel & ~penable & ~hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= VPR_DAT_RST;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata_ff;
      pready_ff  <= nxt_pready_ff;
      pslverr_ff <= nxt_pslverr_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes and pending flags
  always_comb begin
    nxt_multi_vector_select_ff  = multi_vector_select_ff;
    nxt_ss0_ff   = ss0_ff;
    nxt_shlvl_ff = shlvl_ff;
    nxt_pend_ff  = pend_ff;
    nxt_ena_ff   = ena_ff;
    nxt_pri_ff   = pri_ff;
    nxt_sub_ff   = sub_ff;
    if (wr && hit) begin
      if (is_pcfg(paddr)) begin
        for (int j = 0; j < VPR_VEC_PER_REG; j++) begin
          nxt_pri_ff[pcfg_idx(paddr)*4 + j] =
            pwdata[j*VPR_VEC_STRIDE + VPR_PRI_LSB +: 3];
          nxt_sub_ff[pcfg_idx(paddr)*4 + j] =
            pwdata[j*VPR_VEC_STRIDE + VPR_SUB_LSB +: 2];
        end
      end else begin
        case (paddr)
          VPR_CTRL_OFS: begin
            nxt_multi_vector_select_ff  = pwdata[VPR_MULTI_VECTOR_SELECT_BIT];
            nxt_ss0_ff   = pwdata[VPR_SS0_BIT];
            nxt_shlvl_ff = pwdata[VPR_SHLVL_LSB +: 3];
          end
          VPR_PEND0_OFS: nxt_pend_ff[31:0]  = pwdata;
          VPR_PEND1_OFS: nxt_pend_ff[63:32] = pwdata;
          VPR_ENA0_OFS:  nxt_ena_ff[31:0]   = pwdata;
          VPR_ENA1_OFS:  nxt_ena_ff[63:32]  = pwdata;
          default:       nxt_multi_vector_select_ff        = multi_vector_select_ff;
        endcase
      end
    end
    // an event in the clearing cycle survives: set beats clear
    nxt_pend_ff = nxt_pend_ff | src_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multi_vector_select_ff  <= 1'b0;
      ss0_ff   <= 1'b0;
      shlvl_ff <= VPR_LVL_RST;
      pend_ff  <= 64'h0000_0000_0000_0000;
      ena_ff   <= 64'h0000_0000_0000_0000;
      for (int i = 0; i < VPR_NVEC; i++) begin
        pri_ff[i] <= VPR_LVL_RST;
        sub_ff[i] <= 2'h0;
      end
    end else begin
      multi_vector_select_ff  <= nxt_multi_vector_select_ff;
      ss0_ff   <= nxt_ss0_ff;
      shlvl_ff <= nxt_shlvl_ff;
      pend_ff  <= nxt_pend_ff;
      ena_ff   <= nxt_ena_ff;
      pri_ff   <= nxt_pri_ff;
      sub_ff   <= nxt_sub_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ranking and request to the core
  always_comb begin
    for (int i = 0; i < VPR_NVEC; i++) begin
      req[i] = pend_ff[i] & ena_ff[i] &
               (pri_ff[i] != VPR_LVL_RST);
      pri_flat[i*3 +: 3] = pri_ff[i];
      sub_flat[i*2 +: 2] = sub_ff[i];
    end
  end

  vpr_rank u_rank (
    .req      (req),
    .pri_flat (pri_flat),
    .sub_flat (sub_flat),
    .win_any  (win_any),
    .win_lvl  (win_lvl),
    .win_sub  (),
    .win_vec  (win_vec)
  );

  always_comb begin
    // highest level always presented, so it can preempt a lower one
    nxt_lvl_ff = win_any ? win_lvl : VPR_LVL_RST;
    // single mode forces one vector and one address
    nxt_vec_ff = multi_vector_select_ff ? win_vec : 6'h00;
    if (multi_vector_select_ff)
      nxt_set_ff = win_any && (win_lvl == shlvl_ff);
    else
      nxt_set_ff = ss0_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_ff <= VPR_LVL_RST;
      vec_ff <= 6'h00;
      set_ff <= 1'b0;
    end else begin
      lvl_ff <= nxt_lvl_ff;
      vec_ff <= nxt_vec_ff;
      set_ff <= nxt_set_ff;
    end
  end
endmodule
